// >>> rtl/ifl_decoder.sv
// Instruction format and length decoder, byte stream in, records out
`timescale 1ns/1ps
`default_nettype none
`include "ifl_params.svh"
module ifl_decoder #(
   parameter int unsigned MAX_LEN    = `IFL_MAX_LEN,
   parameter int unsigned FIFO_DEPTH = `IFL_FIFO_D
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Default code attributes
   input  wire logic        defAddr32,
   input  wire logic        defOp32,
   // Byte stream from fetch
   input  wire logic [7:0]  inByte,
   input  wire logic        inValid,
   output logic             inReady,
   // Decoded instruction toward the pipeline
   output logic             outValid,
   input  wire logic        outReady,
   output logic [`IFL_ADDR_W-1:0] outStart,
   output logic [3:0]       outLen,
   output logic             outFault,
   output logic [15:0]      outErrCode,
   output logic [3:0]       outPfxCnt,
   output logic             outTwoByte,
   output logic             outHasModrm,
   output logic             outHasSib,
   output logic [2:0]       outDispLen,
   output logic [2:0]       outImmLen,
   output logic [2:0]       outSeg,
   output logic             outOpInv,
   output logic             outAdInv,
   output logic             outLock,
   output logic             outRepNe,
   output logic             outRep,
   output logic [7:0]       outOpcode,
   output logic [1:0]       outMod,
   output logic [2:0]       outReg,
   output logic [2:0]       outRm,
   output logic [1:0]       outScale,
   output logic [2:0]       outIndex,
   output logic [2:0]       outBase
);
   // The length field is four bits wide
   if (MAX_LEN < 1 || MAX_LEN > 15) begin : g_chk
      $error("ifl_decoder: MAX_LEN must be 1..15");
   end

   // Segment override code 1..6, zero when not a segment prefix
   function automatic logic [2:0] segCode(input logic [7:0] b);
      segCode = (b == `IFL_PFX_ES) ? 3'h1 : (b == `IFL_PFX_CS) ? 3'h2 :
                (b == `IFL_PFX_SS) ? 3'h3 : (b == `IFL_PFX_DS) ? 3'h4 :
                (b == `IFL_PFX_FS) ? 3'h5 : (b == `IFL_PFX_GS) ? 3'h6 :
                3'h0;
   endfunction : segCode

   // Opcode class: {needs locator, immediate kind, memory-offset form}
   function automatic logic [3:0] opClass(input logic two,
                                          input logic [7:0] op);
      opClass = {1'h0, `IFL_IMM_NONE, 1'h0};
      if (two) begin
         casez (op)
            8'b1000_????: opClass = {1'h0, `IFL_IMM_V, 1'h0};
            8'hBA, 8'hA4, 8'hAC: opClass = {1'h1, `IFL_IMM_8, 1'h0};
            8'h06, 8'h08, 8'h09, 8'h0B, 8'h30, 8'h31, 8'h32, 8'h33,
            8'h77, 8'hA0, 8'hA1, 8'hA2, 8'hA8, 8'hA9, 8'hAA,
            8'b1100_1???: opClass = {1'h0, `IFL_IMM_NONE, 1'h0};
            default: opClass = {1'h1, `IFL_IMM_NONE, 1'h0};
         endcase
      end else begin
         casez (op)
            8'b00??_?0??, 8'h62, 8'h63, 8'b1000_01??, 8'b1000_1???,
            8'hC4, 8'hC5, 8'b1101_00??, 8'b1101_1???,
            8'hF6, 8'hF7, 8'hFE, 8'hFF:
               opClass = {1'h1, `IFL_IMM_NONE, 1'h0};
            8'b00??_?100, 8'h6A, 8'b0111_????, 8'hA8, 8'b1011_0???,
            8'hCD, 8'hD4, 8'hD5, 8'b1110_0???, 8'hEB:
               opClass = {1'h0, `IFL_IMM_8, 1'h0};
            8'b00??_?101, 8'h68, 8'hA9, 8'b1011_1???, 8'hE8, 8'hE9:
               opClass = {1'h0, `IFL_IMM_V, 1'h0};
            8'h6B, 8'h80, 8'h82, 8'h83, 8'hC0, 8'hC1, 8'hC6:
               opClass = {1'h1, `IFL_IMM_8, 1'h0};
            8'h69, 8'h81, 8'hC7: opClass = {1'h1, `IFL_IMM_V, 1'h0};
            8'hC2, 8'hCA: opClass = {1'h0, `IFL_IMM_16, 1'h0};
            8'b1010_00??: opClass = {1'h0, `IFL_IMM_NONE, 1'h1};
            default: opClass = {1'h0, `IFL_IMM_NONE, 1'h0};
         endcase
      end
   endfunction : opClass

   // Bytes of an immediate of the given kind
   function automatic logic [2:0] immBytes(input logic [1:0] k,
                                           input logic op32);
      unique case (k)
         `IFL_IMM_NONE: immBytes = `IFL_SZ0;
         `IFL_IMM_8:    immBytes = `IFL_SZ8;
         `IFL_IMM_16:   immBytes = `IFL_SZ16;
         default:       immBytes = op32 ? `IFL_SZ32 : `IFL_SZ16;
      endcase
   endfunction : immBytes

   ifl_pkg::ifl_state_t   state_r, state_nxt;  // Parse position
   ifl_pkg::ifl_rec_t     cur_r, cur_nxt;      // Instruction being built
   ifl_pkg::ifl_rec_t     recOut_r, recOut_nxt;// Finished, awaiting queue
   ifl_pkg::ifl_rec_t     head;                // Queue head word
   logic                  recValid_r, recValid_nxt;
   logic                  inReady_r;           // Mirror of free record slot
   logic [2:0]            left_r, left_nxt;    // Field bytes still due
   logic [`IFL_ADDR_W-1:0] addr_r;             // Address of next byte
   logic                  done;                // Instruction ends this byte
   logic                  toTail;              // Addressing part complete
   logic                  fifoReady;
   logic [3:0]            cls;

   wire       acc   = inValid && inReady_r;
   wire [2:0] sc    = segCode(inByte);
   wire       isPfx = (sc != 3'h0) || inByte == `IFL_PFX_OPSZ ||
                      inByte == `IFL_PFX_ADSZ || inByte == `IFL_PFX_LOCK ||
                      inByte == `IFL_PFX_RPNE || inByte == `IFL_PFX_REP;
   wire       a32   = defAddr32 ^ cur_r.adInv;
   wire       o32   = defOp32 ^ cur_r.opInv;
   wire [1:0] bMod  = inByte[`IFL_MOD_HI:`IFL_MOD_LO];
   wire [2:0] bReg  = inByte[`IFL_REG_HI:`IFL_REG_LO];
   wire [2:0] bRm   = inByte[`IFL_RM_HI:`IFL_RM_LO];
   wire       wantSib = a32 && bRm == `IFL_RM_SIB && bMod != `IFL_MOD_DIR;
   wire       fifoTake = recValid_r && fifoReady;

   // Parse one accepted byte and decide where the instruction stands
   always_comb begin
      cur_nxt   = cur_r;
      state_nxt = state_r;
      left_nxt  = left_r;
      done      = 1'h0;
      toTail    = 1'h0;
      cls       = opClass(cur_r.twoByte, inByte);
      if (acc) begin
         cur_nxt.len = cur_r.len + 4'h1;
         unique case (state_r)
            ifl_pkg::ST_FIRST, ifl_pkg::ST_OPC2: begin
               if (state_r == ifl_pkg::ST_FIRST && isPfx) begin
                  // Flags merge by OR and the larger segment code wins,
                  // so any order of prefixes gives one result
                  cur_nxt.pfxCnt = cur_r.pfxCnt + 4'h1;
                  cur_nxt.seg    = (sc > cur_r.seg) ? sc : cur_r.seg;
                  cur_nxt.opInv  = cur_r.opInv | (inByte == `IFL_PFX_OPSZ);
                  cur_nxt.adInv  = cur_r.adInv | (inByte == `IFL_PFX_ADSZ);
                  cur_nxt.lock   = cur_r.lock | (inByte == `IFL_PFX_LOCK);
                  cur_nxt.repNe  = cur_r.repNe | (inByte == `IFL_PFX_RPNE);
                  cur_nxt.rep    = cur_r.rep | (inByte == `IFL_PFX_REP);
               end else if (state_r == ifl_pkg::ST_FIRST &&
                            inByte == `IFL_OPC_ESC) begin
                  cur_nxt.twoByte = 1'h1;
                  state_nxt       = ifl_pkg::ST_OPC2;
               end else begin
                  cur_nxt.opcode   = inByte;
                  cur_nxt.hasModrm = cls[3];
                  cur_nxt.immLen   = immBytes(cls[2:1], o32);
                  if (cls[0]) begin
                     cur_nxt.dispLen = a32 ? `IFL_SZ32 : `IFL_SZ16;
                  end
                  if (cls[3]) state_nxt = ifl_pkg::ST_MODRM;
                  else toTail = 1'h1;
               end
            end
            ifl_pkg::ST_MODRM: begin
               cur_nxt.modrm  = inByte;
               cur_nxt.hasSib = wantSib;
               // Test forms of the unary group carry an immediate
               if (!cur_r.twoByte && cur_r.opcode[7:1] == 7'h7B &&
                   bReg == 3'h0) begin
                  cur_nxt.immLen = immBytes(cur_r.opcode[0] ?
                     `IFL_IMM_V : `IFL_IMM_8, o32);
               end
               if (bMod == 2'h1) cur_nxt.dispLen = `IFL_SZ8;
               else if (bMod == 2'h2) cur_nxt.dispLen =
                  a32 ? `IFL_SZ32 : `IFL_SZ16;
               else if (bMod == 2'h0 && a32 && bRm == `IFL_RM_D32)
                  cur_nxt.dispLen = `IFL_SZ32;
               else if (bMod == 2'h0 && !a32 && bRm == `IFL_RM_D16)
                  cur_nxt.dispLen = `IFL_SZ16;
               if (wantSib) state_nxt = ifl_pkg::ST_SIB;
               else toTail = 1'h1;
            end
            ifl_pkg::ST_SIB: begin
               cur_nxt.sib = inByte;
               // Base 101 without displacement mode means a bare d32
               if (cur_r.modrm[`IFL_MOD_HI:`IFL_MOD_LO] == 2'h0 &&
                   bRm == `IFL_RM_D32) cur_nxt.dispLen = `IFL_SZ32;
               toTail = 1'h1;
            end
            ifl_pkg::ST_DISP: begin
               if (left_r == 3'h1) begin
                  if (cur_r.immLen != `IFL_SZ0) begin
                     state_nxt = ifl_pkg::ST_IMM;
                     left_nxt  = cur_r.immLen;
                  end else done = 1'h1;
               end else left_nxt = left_r - 3'h1;
            end
            ifl_pkg::ST_IMM: begin
               if (left_r == 3'h1) done = 1'h1;
               else left_nxt = left_r - 3'h1;
            end
         endcase
         // Addressing done: move on to displacement, immediate or end
         if (toTail) begin
            if (cur_nxt.dispLen != `IFL_SZ0) begin
               state_nxt = ifl_pkg::ST_DISP;
               left_nxt  = cur_nxt.dispLen;
            end else if (cur_nxt.immLen != `IFL_SZ0) begin
               state_nxt = ifl_pkg::ST_IMM;
               left_nxt  = cur_nxt.immLen;
            end else done = 1'h1;
         end
         // The last allowed byte with more still due is a fault
         if (!done && cur_nxt.len == 4'(MAX_LEN)) begin
            cur_nxt.fault = 1'h1;
            done          = 1'h1;
         end
      end
      recOut_nxt   = done ? cur_nxt : recOut_r;
      recValid_nxt = done || (recValid_r && !fifoTake);
      if (done) begin
         // Prefix state ends with its instruction; next byte starts anew
         state_nxt     = ifl_pkg::ST_FIRST;
         cur_nxt       = '0;
         cur_nxt.start = addr_r + `IFL_ADDR_W'(1);
      end
   end

   // Parse state, byte address and finished-record slot
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= ifl_pkg::ST_FIRST;
         cur_r      <= '0;
         left_r     <= 3'h0;
         addr_r     <= '0;
         recOut_r   <= '0;
         recValid_r <= 1'h0;
         inReady_r  <= 1'h1;
      end else begin
         state_r    <= state_nxt;
         cur_r      <= cur_nxt;
         left_r     <= left_nxt;
         if (acc) addr_r <= addr_r + `IFL_ADDR_W'(1);
         recOut_r   <= recOut_nxt;
         recValid_r <= recValid_nxt;
         inReady_r  <= !recValid_nxt;  // Stall fetch while a finished record awaits the queue
      end
   end

   // Queue of finished records; its back-pressure stalls the parser
   ifl_fifo #(.WIDTH($bits(ifl_pkg::ifl_rec_t)), .DEPTH(FIFO_DEPTH)) u_q (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (recValid_r),
      .inReady  (fifoReady),
      .inData   (recOut_r),
      .outValid (outValid),
      .outReady (outReady),
      .outData  (head)
   );

   // Result fields straight from the queue's head register, except the fixed error code
   assign inReady     = inReady_r;
   assign outStart    = head.start;
   assign outLen      = head.len;
   assign outFault    = head.fault;
   assign outErrCode  = `IFL_GP_ERR;  // Fault always reports code zero
   assign outPfxCnt   = head.pfxCnt;
   assign outTwoByte  = head.twoByte;
   assign outHasModrm = head.hasModrm;
   assign outHasSib   = head.hasSib;
   assign outDispLen  = head.dispLen;
   assign outImmLen   = head.immLen;
   assign outSeg      = head.seg;
   assign outOpInv    = head.opInv;
   assign outAdInv    = head.adInv;
   assign outLock     = head.lock;
   assign outRepNe    = head.repNe;
   assign outRep      = head.rep;
   assign outOpcode   = head.opcode;
   assign outMod      = head.modrm[`IFL_MOD_HI:`IFL_MOD_LO];
   assign outReg      = head.modrm[`IFL_REG_HI:`IFL_REG_LO];
   assign outRm       = head.modrm[`IFL_RM_HI:`IFL_RM_LO];
   assign outScale    = head.sib[`IFL_MOD_HI:`IFL_MOD_LO];
   assign outIndex    = head.sib[`IFL_REG_HI:`IFL_REG_LO];
   assign outBase     = head.sib[`IFL_RM_HI:`IFL_RM_LO];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   len_range_a: assert property (recValid_r |-> recOut_r.len >= 4'h1 &&
      recOut_r.len <= 4'(MAX_LEN)) else $error("length out of range");
   fault_len_a: assert property (done && cur_nxt.fault |=>
      recValid_r && recOut_r.len == 4'(MAX_LEN))
      else $error("fault not at maximum length");
   sib_order_a: assert property (recValid_r && recOut_r.hasSib |->
      recOut_r.hasModrm) else $error("sib without locator");
   next_start_a: assert property (done |=> cur_r.start ==
      recOut_r.start + `IFL_ADDR_W'(recOut_r.len))
      else $error("next start not after previous instruction");
   field_size_a: assert property (recValid_r |->
      recOut_r.dispLen inside {3'h0, 3'h1, 3'h2, 3'h4} &&
      recOut_r.immLen inside {3'h0, 3'h1, 3'h2, 3'h4})
      else $error("illegal field size");
   pfx_reset_a: assert property (done |=> cur_r.pfxCnt == 4'h0 &&
      !cur_r.lock && cur_r.seg == 3'h0) else $error("prefix leaked");
   seg_take_a: assert property (acc && state_r == ifl_pkg::ST_FIRST &&
      inByte == `IFL_PFX_ES && !done |=> cur_r.seg != 3'h0)
      else $error("segment prefix missed");
   sib_expect_a: assert property (acc &&
      state_r == ifl_pkg::ST_MODRM && wantSib && !done |=>
      state_r == ifl_pkg::ST_SIB) else $error("sib not expected");
   len_sum_a: assert property (recValid_r && !recOut_r.fault |->
      recOut_r.len == recOut_r.pfxCnt + 4'(recOut_r.twoByte) + 4'h1 +
      4'(recOut_r.hasModrm) + 4'(recOut_r.hasSib) +
      4'(recOut_r.dispLen) + 4'(recOut_r.immLen))
      else $error("length differs from sum of fields");
endmodule : ifl_decoder
`default_nettype wire

// >>> rtl/ifl_params.svh
// Constants of the instruction format and length decoder
`ifndef IFL_PARAMS_SVH
`define IFL_PARAMS_SVH
`define IFL_ADDR_W   32
`define IFL_MAX_LEN  15
`define IFL_FIFO_D   8
`define IFL_GP_ERR   16'h0000
// Prefix byte values
`define IFL_PFX_ES   8'h26
`define IFL_PFX_CS   8'h2E
`define IFL_PFX_SS   8'h36
`define IFL_PFX_DS   8'h3E
`define IFL_PFX_FS   8'h64
`define IFL_PFX_GS   8'h65
`define IFL_PFX_OPSZ 8'h66
`define IFL_PFX_ADSZ 8'h67
`define IFL_PFX_LOCK 8'hF0
`define IFL_PFX_RPNE 8'hF2
`define IFL_PFX_REP  8'hF3
`define IFL_OPC_ESC  8'h0F
// Bit splits of the operand-locator and scale-index-base bytes
`define IFL_MOD_HI   7
`define IFL_MOD_LO   6
`define IFL_REG_HI   5
`define IFL_REG_LO   3
`define IFL_RM_HI    2
`define IFL_RM_LO    0
`define IFL_MOD_DIR  2'h3
`define IFL_RM_SIB   3'h4
`define IFL_RM_D32   3'h5
`define IFL_RM_D16   3'h6
// Immediate kinds and field sizes in bytes
`define IFL_IMM_NONE 2'h0
`define IFL_IMM_8    2'h1
`define IFL_IMM_16   2'h2
`define IFL_IMM_V    2'h3
`define IFL_SZ0      3'h0
`define IFL_SZ8      3'h1
`define IFL_SZ16     3'h2
`define IFL_SZ32     3'h4
`endif

// >>> rtl/ifl_pkg.sv
// Types shared by the instruction format and length decoder
`include "ifl_params.svh"
package ifl_pkg;
   // Parse position inside one instruction
   typedef enum logic [2:0] {
      ST_FIRST, ST_OPC2, ST_MODRM, ST_SIB, ST_DISP, ST_IMM
   } ifl_state_t;

   // One decoded instruction, as queued toward the pipeline
   typedef struct packed {
      logic [`IFL_ADDR_W-1:0] start;
      logic [3:0]             len;
      logic [3:0]             pfxCnt;
      logic                   twoByte;
      logic                   hasModrm;
      logic                   hasSib;
      logic [2:0]             dispLen;
      logic [2:0]             immLen;
      logic                   fault;
      logic [2:0]             seg;
      logic                   opInv;
      logic                   adInv;
      logic                   lock;
      logic                   repNe;
      logic                   rep;
      logic [7:0]             opcode;
      logic [7:0]             modrm;
      logic [7:0]             sib;
   } ifl_rec_t;
endpackage : ifl_pkg

// >>> rtl/ifl_fifo.sv
// Result queue with a registered head word
`timescale 1ns/1ps
`default_nettype none
module ifl_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int unsigned AW = $clog2(DEPTH);

   // Pointers wrap naturally, so the depth must be a power of two
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("ifl_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];   // Storage words
   logic [AW-1:0]    wrPtr_r;       // Next slot to write
   logic [AW-1:0]    rdPtr_r;       // Next slot to read
   logic [AW:0]      cnt_r;         // Words in storage
   logic             headValid_r;   // Head register holds a word
   logic [WIDTH-1:0] headData_r;    // Head word, drives the output

   wire push = inValid && inReady;
   // Refill the head when it is empty or being taken this cycle
   wire load = (cnt_r != '0) && (!headValid_r || outReady);

   assign inReady  = (cnt_r != (AW+1)'(DEPTH));
   assign outValid = headValid_r;
   assign outData  = headData_r;

   // Storage write; no reset needed on data words
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   // Pointers, fill count and head register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_r     <= '0;
         rdPtr_r     <= '0;
         cnt_r       <= '0;
         headValid_r <= 1'h0;
         headData_r  <= '0;
      end else begin
         if (push) wrPtr_r <= wrPtr_r + AW'(1);
         if (load) rdPtr_r <= rdPtr_r + AW'(1);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
         if (load) begin
            headValid_r <= 1'h1;
            headData_r  <= mem[rdPtr_r];
         end else if (outReady) begin
            headValid_r <= 1'h0;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Never more words than slots, and a full queue refuses data
   fifo_bound_a: assert property (cnt_r <= (AW+1)'(DEPTH) &&
      (cnt_r != (AW+1)'(DEPTH) || !inReady))
      else $error("fifo occupancy out of range");
   // A held head word stays put while the drain side stalls
   head_hold_a: assert property (outValid && !outReady |=>
      outValid && $stable(outData))
      else $error("fifo head changed under stall");
endmodule : ifl_fifo
`default_nettype wire

// >>> testbench/ifl_fetch_model.sv
// Fetch-side byte feeder that stands in front of the decoder
`timescale 1ns/1ps
`default_nettype none
module ifl_fetch_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Byte stream toward the decoder
   output logic [7:0]      inByte,
   output logic            inValid,
   input  wire logic       inReady
);
   logic [7:0] q[$];  // Bytes still to hand over
   // Offer the head byte; an idle bus toggles so stale data never matches
   always @(negedge clk) begin
      if (rst_n && q.size() != 0) begin
         inValid = 1'b1;
         inByte  = q[0];
      end else begin
         inValid = 1'b0;
         inByte  = ~inByte;
      end
   end
   // A byte leaves only at the edge that takes it
   always @(posedge clk) begin
      if (inValid && inReady) begin
         void'(q.pop_front());
      end
   end
   initial begin
      inValid = 1'b0;
      inByte  = 8'h00;
   end
endmodule : ifl_fetch_model
`default_nettype wire

// >>> testbench/tb_ifl_decoder.sv
// Self-checking bench for the instruction format and length decoder
`timescale 1ns/1ps
`default_nettype none
`include "ifl_params.svh"
module tb_ifl_decoder;
   logic        clk, rst_n, defAddr32, defOp32, inValid, inReady;
   logic        outValid, outReady, outFault, outTwoByte, outHasModrm;
   logic        outHasSib, outOpInv, outAdInv, outLock, outRepNe, outRep;
   logic [7:0]  inByte, outOpcode;
   logic [`IFL_ADDR_W-1:0] outStart, nextStart;  // Expected start address
   logic [15:0] outErrCode;
   logic [3:0]  outLen, outPfxCnt;
   logic [2:0]  outDispLen, outImmLen, outSeg, outReg, outRm, outIndex, outBase;
   logic [1:0]  outMod, outScale;
   logic [97:0] seen[$];  // Records taken on the pipeline side
   int          n_errors, n_checks;

   ifl_decoder u_ifl_decoder (
      .clk, .rst_n, .defAddr32, .defOp32, .inByte, .inValid, .inReady,
      .outValid, .outReady, .outStart, .outLen, .outFault, .outErrCode,
      .outPfxCnt, .outTwoByte, .outHasModrm, .outHasSib, .outDispLen,
      .outImmLen, .outSeg, .outOpInv, .outAdInv, .outLock, .outRepNe,
      .outRep, .outOpcode, .outMod, .outReg, .outRm, .outScale,
      .outIndex, .outBase);
   ifl_fetch_model u_ifl_fetch_model (
      .clk, .rst_n, .inByte, .inValid, .inReady);

   // Capture each record at the edge that takes it
   always @(posedge clk) begin
      if (rst_n && outValid && outReady) begin
         seen.push_back({outStart, outLen, outFault, outErrCode, outPfxCnt,
            outTwoByte, outHasModrm, outHasSib, outDispLen, outImmLen,
            outSeg, outOpInv, outAdInv, outLock, outRepNe, outRep,
            outOpcode, outMod, outReg, outRm, outScale, outIndex, outBase});
      end
   end

   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) u_ifl_fetch_model.q.push_back(b[i]);
   endtask : send

   // Locator and sib bytes map straight onto mod/reg/rm and scale/idx/base;
   // with full low only start, length, fault and code are compared
   task automatic chk_rec(input logic [3:0] len, input logic flt, full,
      input logic [3:0] pfx, input logic [2:0] shape, dl, il, sg,
      input logic [4:0] fl, input logic [7:0] opc, m, s);
      logic [97:0] e, mask, got;
      int          t;
      e = {nextStart, len, flt, `IFL_GP_ERR, pfx, shape, dl, il, sg, fl,
         opc, m, s};
      mask = full ? {98{1'b1}} : {{53{1'b1}}, 45'h0};
      t = 0;
      while (seen.size() == 0 && t < 400) begin
         @(negedge clk);
         t++;
      end
      got = (seen.size() != 0) ? seen.pop_front() : {98{1'bx}};
      n_checks++;
      if (((got ^ e) & mask) !== 98'h0) begin
         n_errors++;
         $display("unexpected record: expected %h seen %h", e & mask, got);
      end
      nextStart = nextStart + len;
   endtask : chk_rec

   task automatic s_plain;
      send({8'h04, 8'h12});
      chk_rec(4'h2, 0, 1, 4'h0, 3'h0, 3'h0, 3'h1, 3'h0, 5'h00, 8'h04, 8'h00, 8'h00);
      send({8'h90});
      chk_rec(4'h1, 0, 1, 4'h0, 3'h0, 3'h0, 3'h0, 3'h0, 5'h00, 8'h90, 8'h00, 8'h00);
      send({8'h0F, 8'hAF, 8'hC1});
      chk_rec(4'h3, 0, 1, 4'h0, 3'h6, 3'h0, 3'h0, 3'h0, 5'h00, 8'hAF, 8'hC1, 8'h00);
   endtask : s_plain

   // Same prefixes in two orders, then a bare opcode that must see none
   task automatic s_prefix;
      send({8'h66, 8'h26, 8'h3E, 8'h89, 8'h44, 8'h24, 8'h08});
      chk_rec(4'h7, 0, 1, 4'h3, 3'h3, 3'h1, 3'h0, 3'h4, 5'h10, 8'h89, 8'h44, 8'h24);
      send({8'h3E, 8'h26, 8'h66, 8'h89, 8'h44, 8'h24, 8'h08});
      chk_rec(4'h7, 0, 1, 4'h3, 3'h3, 3'h1, 3'h0, 3'h4, 5'h10, 8'h89, 8'h44, 8'h24);
      send({8'hF0, 8'hF3, 8'hF2, 8'h67, 8'hA4, 8'h90});
      chk_rec(4'h5, 0, 1, 4'h4, 3'h0, 3'h0, 3'h0, 3'h0, 5'h0F, 8'hA4, 8'h00, 8'h00);
      chk_rec(4'h1, 0, 1, 4'h0, 3'h0, 3'h0, 3'h0, 3'h0, 5'h00, 8'h90, 8'h00, 8'h00);
   endtask : s_prefix

   task automatic s_segs;
      logic [7:0] seg[6];
      seg = '{8'h26, 8'h2E, 8'h36, 8'h3E, 8'h64, 8'h65};
      for (int i = 0; i < 6; i++) begin
         send({seg[i], 8'h90});
         chk_rec(4'h2, 0, 1, 4'h1, 3'h0, 3'h0, 3'h0, 3'(i + 1), 5'h00, 8'h90, 8'h00, 8'h00);
      end
   endtask : s_segs

   // 32-bit and 16-bit displacement and immediate sizing
   task automatic s_sizes;
      send({8'hC7, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
      chk_rec(4'hA, 0, 1, 4'h0, 3'h2, 3'h4, 3'h4, 3'h0, 5'h00, 8'hC7, 8'h05, 8'h00);
      send({8'h66, 8'hC7, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
      chk_rec(4'h9, 0, 1, 4'h1, 3'h2, 3'h4, 3'h2, 3'h0, 5'h10, 8'hC7, 8'h05, 8'h00);
      @(negedge clk);
      defAddr32 = 1'b0;  // Decoder idle here, so the switch hits no instruction
      send({8'h8B, 8'h06, 8'h34, 8'h12, 8'h8B, 8'h04});
      chk_rec(4'h4, 0, 1, 4'h0, 3'h2, 3'h2, 3'h0, 3'h0, 5'h00, 8'h8B, 8'h06, 8'h00);
      chk_rec(4'h2, 0, 1, 4'h0, 3'h2, 3'h0, 3'h0, 3'h0, 5'h00, 8'h8B, 8'h04, 8'h00);
      @(negedge clk);
      defAddr32 = 1'b1;
   endtask : s_sizes

   // Memory-offset, unary test and two-byte branch forms
   task automatic s_forms;
      send({8'hA1, 8'h01, 8'h02, 8'h03, 8'h04});
      chk_rec(4'h5, 0, 1, 4'h0, 3'h0, 3'h4, 3'h0, 3'h0, 5'h00, 8'hA1, 8'h00, 8'h00);
      send({8'hF6, 8'hC0, 8'h12});
      chk_rec(4'h3, 0, 1, 4'h0, 3'h2, 3'h0, 3'h1, 3'h0, 5'h00, 8'hF6, 8'hC0, 8'h00);
      send({8'h0F, 8'h84, 8'h01, 8'h02, 8'h03, 8'h04});
      chk_rec(4'h6, 0, 1, 4'h0, 3'h4, 3'h0, 3'h4, 3'h0, 5'h00, 8'h84, 8'h00, 8'h00);
   endtask : s_forms

   // Fifteen prefixes leave no room; the next byte starts afresh
   task automatic s_fault;
      repeat (15) u_ifl_fetch_model.q.push_back(8'h66);
      send({8'h90});
      chk_rec(4'hF, 1, 0, 4'h0, 3'h0, 3'h0, 3'h0, 3'h0, 5'h00, 8'h00, 8'h00, 8'h00);
      chk_rec(4'h1, 0, 1, 4'h0, 3'h0, 3'h0, 3'h0, 3'h0, 5'h00, 8'h90, 8'h00, 8'h00);
   endtask : s_fault

   // Pipeline stalls until the queue refuses, then drains in order
   task automatic s_stall;
      @(negedge clk);
      outReady = 1'b0;
      repeat (12) u_ifl_fetch_model.q.push_back(8'h90);
      repeat (40) @(negedge clk);
      n_checks++;
      if (inReady !== 1'b0) begin
         n_errors++;
         $display("unexpected inReady: expected 0 seen %b", inReady);
      end
      outReady = 1'b1;
      repeat (12) chk_rec(4'h1, 0, 1, 4'h0, 3'h0, 3'h0, 3'h0, 3'h0, 5'h00, 8'h90, 8'h00, 8'h00);
   endtask : s_stall

   task complete_run;
      if (n_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run needs well under 2000 cycles
   initial begin
      #100000;
      n_errors++;
      complete_run;
   end
   initial begin
      rst_n = 1'b0;
      defAddr32 = 1'b1;
      defOp32 = 1'b1;
      outReady = 1'b1;
      n_errors = 0;
      n_checks = 0;
      nextStart = '0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      s_plain;
      s_prefix;
      s_segs;
      s_sizes;
      s_forms;
      s_fault;
      s_stall;
      complete_run;
   end
endmodule : tb_ifl_decoder
`default_nettype wire
